/* rvtm_addr_gen.sv */
// Combinational vector address generator
module rvtm_addr_gen
	import rvtm_pkg::*;
(
	input  wire logic [6:0]  i_vec_num,
	input  wire logic        i_alt_table_select,
	output logic      [23:0] o_vec_addr
);
	import rvtm_pkg::*;
	wire logic [23:0] base;
	wire logic [23:0] ofs;
	assign base = i_alt_table_select ? RVTM_ALT_BASE : RVTM_PRI_BASE;
	assign ofs  = {16'h0000, i_vec_num, 1'b0};
	assign o_vec_addr = base + ofs;
endmodule : rvtm_addr_gen

/* rvtm_cpu_model.sv */
// CPU fetch side: acks vector requests and returns table entries
module rvtm_cpu_model
	import rvtm_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_vec_req,
	input  wire logic [23:0] i_vec_addr,
	input  wire logic [1:0]  i_delay,
	output logic             o_vec_ack,
	output logic             o_entry_valid,
	output logic      [23:0] o_entry_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] wait_cnt;
	always_ff @(posedge i_sys_clk) begin
		o_vec_ack     <= 1'b0;
		o_entry_valid <= o_vec_ack;
		if (!i_resetn) begin
			wait_cnt      <= 2'h0;
			o_entry_valid <= 1'b0;
		end else if (i_vec_req && !o_vec_ack) begin
			wait_cnt  <= (wait_cnt == i_delay) ? 2'h0 : wait_cnt + 2'h1;
			o_vec_ack <= (wait_cnt == i_delay);
		end
	end
	always_ff @(posedge i_sys_clk) begin
		// Data is only good with valid, so scramble it otherwise
		o_entry_data <= o_vec_ack ? i_vec_addr + 24'h000400 : ~o_entry_data;
	end
endmodule : rvtm_cpu_model

/* rvtm_pkg.sv */
// Package for the reset and vector table map block
package rvtm_pkg;
	localparam int          RVTM_ADDR_W       = 24;
	localparam int          RVTM_VEC_W        = 7;
	localparam int          RVTM_NUM_TRAPS    = 8;
	localparam int          RVTM_NUM_IRQS     = 118;
	localparam int          RVTM_NUM_VECS     = 126;
	localparam logic [23:0] RVTM_RESET_ADDR   = 24'h000000;
	localparam logic [23:0] RVTM_PRI_BASE     = 24'h000004;
	localparam logic [23:0] RVTM_ALT_BASE     = 24'h000104;
	localparam logic [23:0] RVTM_ALT_START    = 24'h000100;
	localparam logic [23:0] RVTM_ALT_END      = 24'h0001fe;
	localparam logic [23:0] RVTM_CODE_START   = 24'h000200;
	localparam logic [6:0]  RVTM_IRQ_VEC_OFS  = 7'h08;
	localparam logic [23:0] RVTM_HANDLER_RST  = 24'h000000;
	// Trap vector numbers
	localparam logic [6:0]  RVTM_TRAP_OSC     = 7'h01;
	localparam logic [6:0]  RVTM_TRAP_ADDR    = 7'h02;
	localparam logic [6:0]  RVTM_TRAP_STACK   = 7'h03;
	localparam logic [6:0]  RVTM_TRAP_MATH    = 7'h04;
	// Source bit positions on the request bus
	localparam int SRC_EXT0 = 0, SRC_CAP1 = 1, SRC_CMP1 = 2, SRC_TMR1 = 3;
	localparam int SRC_CAP2 = 4, SRC_CMP2 = 5, SRC_TMR2 = 6, SRC_TMR3 = 7;
	localparam int SRC_SPIE = 8, SRC_SPID = 9, SRC_URX = 10, SRC_UTX = 11;
	localparam int SRC_ADC = 12, SRC_TWS = 13, SRC_TWM = 14, SRC_CMPA = 15;
	localparam int SRC_CHG = 16, SRC_EXT1 = 17, SRC_EXT2 = 18, SRC_CAP3 = 19;
	localparam int SRC_PWM = 20, SRC_CAL = 21, SRC_FLTA = 22, SRC_FLTB = 23;
	localparam int SRC_UERR = 24, SRC_CTM = 25;
	localparam int RVTM_NUM_SRC = 26;
	typedef enum logic [1:0] {
		RVTM_ST_RESET = 2'b00,
		RVTM_ST_BOOT  = 2'b01,
		RVTM_ST_RUN   = 2'b11
	} rvtm_state_t;
	localparam logic [RVTM_NUM_SRC*7-1:0] RVTM_SRC_VEC = {
		7'd85, 7'd73, 7'd72, 7'd71, 7'd70, 7'd65, 7'd45, 7'd37,
		7'd28, 7'd27, 7'd26, 7'd25, 7'd24, 7'd21, 7'd20, 7'd19,
		7'd18, 7'd17, 7'd16, 7'd15, 7'd14, 7'd13, 7'd11, 7'd10,
		7'd9, 7'd8};
endpackage : rvtm_pkg

/* rvtm_vector_map.sv */
// Reset and vector table map: resolves exception entry to program addresses
module rvtm_vector_map
	import rvtm_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_alt_table_select,
	input  wire logic [3:0]  i_trap_req,
	input  wire logic [25:0] i_irq_req,
	input  wire logic        i_vec_ack,
	input  wire logic        i_entry_valid,
	input  wire logic [23:0] i_entry_data,
	output logic      [23:0] o_vec_addr,
	output logic             o_vec_req,
	output logic      [6:0]  o_vec_num,
	output logic      [23:0] o_pc,
	output logic             o_pc_load,
	output logic             o_in_alt_range,
	output logic             o_boot_fetch
);
	import rvtm_pkg::*;

	rvtm_state_t state;
	rvtm_state_t next_state;
	logic [23:0] pc;
	logic [6:0]  vec_num;
	logic        vec_req;
	logic        pc_load;
	logic        boot_fetch;
	logic [23:0] vec_addr;
	logic        in_alt;

	wire logic [6:0]   sel_vec;
	wire logic         any_req;
	wire logic [23:0]  comb_addr;
	wire logic [RVTM_NUM_VECS-1:0] vec_pend;

	// only wired sources reach vector slots
	genvar g;
	generate
		for (g = 0; g < RVTM_NUM_VECS; g++) begin : g_slot
			if (g == RVTM_TRAP_OSC || g == RVTM_TRAP_ADDR || g == RVTM_TRAP_STACK || g == RVTM_TRAP_MATH) begin : g_trap
				assign vec_pend[g] = i_trap_req[g-1];
			end else begin : g_irq
				logic hit;
				always_comb begin
					hit = 1'b0;
					for (int s = 0; s < RVTM_NUM_SRC; s++) begin
						if (RVTM_SRC_VEC[s*7 +: 7] == 7'(g))
							hit = i_irq_req[s];
					end
				end
				assign vec_pend[g] = hit;
			end
		end
	endgenerate

	genvar t;
	generate
		for (t = 0; t < $bits(i_trap_req); t++) begin : g_trap_chk
			property p_trap_map;
				@(posedge i_sys_clk) disable iff (!i_resetn)
					$rose(o_vec_req) && o_vec_num == RVTM_TRAP_OSC + 7'(t) |-> $past(i_trap_req[t]);
			endproperty
			a_trap_map: assert property (p_trap_map) else $error("trap vector mismatch");
		end
	endgenerate

	genvar sc;
	generate
		for (sc = 0; sc < RVTM_NUM_SRC; sc++) begin : g_src_chk
			property p_src_map;
				@(posedge i_sys_clk) disable iff (!i_resetn)
					$rose(o_vec_req) && o_vec_num == RVTM_SRC_VEC[sc*7 +: 7] |-> $past(i_irq_req[sc]);
			endproperty
			a_src_map: assert property (p_src_map) else $error("source vector mismatch");
		end
	endgenerate

	// Lowest pending vector number
	// Scans from the top so the last hit wins; one pass, no priority tree
	function automatic logic [6:0] lowest_set(input logic [RVTM_NUM_VECS-1:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = RVTM_NUM_VECS - 1; i >= 0; i--) begin
			if (v[i])
				r = 7'(i);
		end
		return r;
	endfunction : lowest_set

	assign sel_vec = lowest_set(vec_pend);
	assign any_req = |vec_pend;

	// Vectors that would have beaten the captured one
	wire logic [RVTM_NUM_VECS-1:0] below_mask;
	genvar m;
	generate
		for (m = 0; m < RVTM_NUM_VECS; m++) begin : g_below
			assign below_mask[m] = (7'(m) < vec_num);
		end
	endgenerate

	property p_prio_lowest;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) |-> ($past(vec_pend) & below_mask) == '0;
	endproperty
	a_prio_lowest: assert property (p_prio_lowest) else $error("lower vector was pending");

	rvtm_addr_gen u_addr_gen (
		.i_vec_num          (sel_vec),
		.i_alt_table_select (i_alt_table_select),
		.o_vec_addr         (comb_addr)
	);

	// Two steps after reset keep the boot fetch clear of any capture
	always_comb begin
		next_state = state;
		case (state)
			RVTM_ST_RESET: next_state = RVTM_ST_BOOT;
			RVTM_ST_BOOT:  next_state = RVTM_ST_RUN;
			RVTM_ST_RUN:   next_state = RVTM_ST_RUN;
			default:       next_state = RVTM_ST_RESET;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state      <= RVTM_ST_RESET;
			pc         <= RVTM_RESET_ADDR;
			vec_num    <= 7'h00;
			vec_req    <= 1'b0;
			pc_load    <= 1'b0;
			boot_fetch <= 1'b0;
			vec_addr   <= RVTM_RESET_ADDR;
			in_alt     <= 1'b0;
		end else begin
			state      <= next_state;
			boot_fetch <= (state == RVTM_ST_RESET);
			pc_load    <= i_entry_valid;
			if (i_entry_valid)
				pc <= i_entry_data;
			if (vec_req && i_vec_ack)
				vec_req <= 1'b0;
			else if (!vec_req && any_req && state == RVTM_ST_RUN) begin
				vec_req  <= 1'b1;
				vec_num  <= sel_vec;
				vec_addr <= comb_addr;
			end
			// alternate table range
			// Follows the live choice, so it pairs with the address only at capture
			in_alt <= (comb_addr >= RVTM_ALT_START) && (comb_addr <= RVTM_ALT_END);
		end
	end

	assign o_vec_addr     = vec_addr;
	assign o_vec_req      = vec_req;
	assign o_vec_num      = vec_num;
	assign o_pc           = pc;
	assign o_pc_load      = pc_load;
	assign o_in_alt_range = in_alt;
	assign o_boot_fetch   = boot_fetch;

	// Reset leaves counter at zero with no request
	property p_reset_pc;
		@(posedge i_sys_clk) !i_resetn |=> (o_pc == RVTM_RESET_ADDR) && !o_vec_req;
	endproperty
	a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");

	sequence s_release;
		!i_resetn ##1 i_resetn;
	endsequence
	property p_boot;
		@(posedge i_sys_clk) s_release |=> o_boot_fetch && o_pc == RVTM_RESET_ADDR;
	endproperty
	a_boot: assert property (p_boot) else $error("no boot fetch at zero");

	property p_no_reset_vec;
		@(posedge i_sys_clk) disable iff (!i_resetn) o_boot_fetch |-> !o_vec_req;
	endproperty
	a_no_reset_vec: assert property (p_no_reset_vec) else $error("vector during reset");

	property p_addr;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) |-> o_vec_addr == ($past(i_alt_table_select) ? RVTM_ALT_BASE : RVTM_PRI_BASE)
				+ {16'h0000, o_vec_num, 1'b0};
	endproperty
	a_addr: assert property (p_addr) else $error("vector address wrong");

	property p_irq_ofs;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) && o_vec_num >= RVTM_IRQ_VEC_OFS && !$past(i_alt_table_select)
				|-> o_vec_addr >= 24'h000014;
	endproperty
	a_irq_ofs: assert property (p_irq_ofs) else $error("irq below table");

	property p_prio;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) && $past(i_trap_req[0]) |-> o_vec_num <= RVTM_TRAP_OSC;
	endproperty
	a_prio: assert property (p_prio) else $error("priority order wrong");

	property p_reserved;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_vec_req |-> o_vec_num != 7'd12 && o_vec_num != 7'd0 && o_vec_num < 7'd86;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved vector fetched");

	property p_load;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			i_entry_valid |=> o_pc_load && o_pc == $past(i_entry_data);
	endproperty
	a_load: assert property (p_load) else $error("handler not loaded");

	property p_boot_pulse;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_boot_fetch |=> !o_boot_fetch;
	endproperty
	a_boot_pulse: assert property (p_boot_pulse) else $error("boot fetch too long");

	property p_no_early_req;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_boot_fetch |=> !o_vec_req;
	endproperty
	a_no_early_req: assert property (p_no_early_req) else $error("vector right after boot");

	// request n at base plus 2n
	wire logic [6:0]  irq_idx;
	wire logic [23:0] irq_pri_base;
	wire logic [23:0] irq_alt_base;
	assign irq_idx      = vec_num - RVTM_IRQ_VEC_OFS;
	assign irq_pri_base = RVTM_PRI_BASE + {16'h0000, RVTM_IRQ_VEC_OFS, 1'b0};
	assign irq_alt_base = RVTM_ALT_BASE + {16'h0000, RVTM_IRQ_VEC_OFS, 1'b0};
	property p_irq_addr;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) && o_vec_num >= RVTM_IRQ_VEC_OFS
				|-> o_vec_addr == ($past(i_alt_table_select) ? irq_alt_base : irq_pri_base)
					+ {16'h0000, irq_idx, 1'b0};
	endproperty
	a_irq_addr: assert property (p_irq_addr) else $error("interrupt address wrong");

	property p_in_table;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_vec_req |-> o_vec_addr >= RVTM_PRI_BASE && o_vec_addr < RVTM_CODE_START;
	endproperty
	a_in_table: assert property (p_in_table) else $error("vector outside tables");

	property p_alt_route;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) |-> o_in_alt_range == $past(i_alt_table_select)
				&& (o_vec_addr >= RVTM_ALT_START) == $past(i_alt_table_select);
	endproperty
	a_alt_route: assert property (p_alt_route) else $error("wrong table used");

	property p_trap_reserved;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_vec_req |-> !(o_vec_num > RVTM_TRAP_MATH && o_vec_num < RVTM_IRQ_VEC_OFS);
	endproperty
	a_trap_reserved: assert property (p_trap_reserved) else $error("reserved trap fetched");

	property p_hold;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			o_vec_req && !i_vec_ack |=> o_vec_req && $stable(o_vec_num) && $stable(o_vec_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");

	property p_capture;
		@(posedge i_sys_clk) disable iff (!i_resetn)
			$rose(o_vec_req) |-> o_vec_addr == $past(comb_addr) && o_vec_num == $past(sel_vec);
	endproperty
	a_capture: assert property (p_capture) else $error("capture not same cycle");
endmodule : rvtm_vector_map

/* testbench.sv */
// Self-checking bench for the vector map with a CPU fetch model
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import rvtm_pkg::*;
	logic        i_sys_clk, i_resetn, i_alt_table_select, ack, ev, vec_req, pc_load, in_alt, boot;
	logic [3:0]  i_trap_req;
	logic [25:0] i_irq_req;
	logic [1:0]  delay;
	logic [6:0]  vec_num;
	logic [23:0] vec_addr, pc, edata;
	int          failures, comparisons, nboot;
	// Expected vector per row: traps 1..4, then sources 0..25
	int vtab [30] = '{1, 2, 3, 4, 8, 9, 10, 11, 13, 14, 15, 16, 17, 18, 19, 20, 21,
		24, 25, 26, 27, 28, 37, 45, 65, 70, 71, 72, 73, 85};
	rvtm_vector_map dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_alt_table_select(i_alt_table_select),
		.i_trap_req(i_trap_req), .i_irq_req(i_irq_req), .i_vec_ack(ack), .i_entry_valid(ev),
		.i_entry_data(edata), .o_vec_addr(vec_addr), .o_vec_req(vec_req), .o_vec_num(vec_num), .o_pc(pc),
		.o_pc_load(pc_load), .o_in_alt_range(in_alt), .o_boot_fetch(boot));
	rvtm_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_vec_req(vec_req), .i_vec_addr(vec_addr),
		.i_delay(delay), .o_vec_ack(ack), .o_entry_valid(ev), .o_entry_data(edata));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	// One full vector exchange, request dropped once captured
	task automatic run(input logic [3:0] t, input logic [25:0] q, input logic a, input int v);
		logic [23:0] exp_addr;
		exp_addr = (a ? 24'h000104 : 24'h000004) + 24'(2 * v);
		@(posedge i_sys_clk);
		i_trap_req         <= t;
		i_irq_req          <= q;
		i_alt_table_select <= a;
		for (int n = 0; n < 20 && vec_req !== 1'b1; n++) @(negedge i_sys_clk);
		check(24'(vec_num), 24'(v));
		check(vec_addr, exp_addr);
		check(24'(in_alt), 24'(a));
		@(posedge i_sys_clk);
		i_trap_req <= 4'h0;
		i_irq_req  <= 26'h0;
		for (int n = 0; n < 20 && pc_load !== 1'b1; n++) @(negedge i_sys_clk);
		check(pc, exp_addr + 24'h000400);
		repeat (2) @(posedge i_sys_clk);
		$display("test vector %0d done", v);
	endtask : run
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		#(25 * 4000);
		failures++;
		tally_and_finish();
	end
	initial begin
		i_resetn = 1'b0;
		i_alt_table_select = 1'b0;
		i_trap_req = 4'h0;
		i_irq_req = 26'h0;
		delay = 2'h0;
		repeat (4) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (4) begin
			@(negedge i_sys_clk);
			nboot += int'(boot === 1'b1);
			check(24'(vec_req), 24'h0);
			check(pc, 24'h000000);
		end
		check(24'(nboot), 24'h1);
		$display("test reset done");
		for (int i = 0; i < 30; i++) begin
			delay <= 2'(i % 3);
			run(i < 4 ? 4'(1 << i) : 4'h0, i < 4 ? 26'h0 : 26'(1) << (i - 4), i[0], vtab[i]);
		end
		run(4'hf, '1, 1'b1, 1);
		run(4'h0, (26'(1) << 3) | (26'(1) << 25), 1'b0, 11);
		@(posedge i_sys_clk);
		i_irq_req <= 26'h1;
		for (int n = 0; n < 20 && vec_req !== 1'b1; n++) @(negedge i_sys_clk);
		@(posedge i_sys_clk);
		i_resetn  <= 1'b0;
		// Left pending through reset to catch an early capture
		i_irq_req <= 26'h2;
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check(24'(vec_req), 24'h0);
		check(pc, 24'h000000);
		@(posedge i_sys_clk);
		i_resetn <= 1'b1;
		nboot = 0;
		for (int n = 0; n < 4; n++) begin
			@(negedge i_sys_clk);
			nboot += int'(boot === 1'b1);
			if (n < 3)
				check(24'(vec_req), 24'h0);
		end
		check(24'(nboot), 24'h1);
		check(24'(vec_req), 24'h1);
		check(24'(vec_num), 24'd9);
		check(vec_addr, 24'h000016);
		@(posedge i_sys_clk);
		i_irq_req <= 26'h0;
		for (int n = 0; n < 20 && pc_load !== 1'b1; n++) @(negedge i_sys_clk);
		check(pc, 24'h000416);
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule : testbench
